/* src/adc_out_proc.sv */
// Output processing, formatting and multiplexing of both channels.
`timescale 1ns/1ps
module adc_out_proc
	import adc_proc_pkg::*;
(
	// System clock and reset.
	input wire logic sys_clk,
	input wire logic srst,
	// Sample clock of the link side.
	input wire logic sample_clk,
	// Converter cores, offset binary, on sample_clk.
	input sample_s core_a,
	input sample_s core_b,
	// Configuration from system side.
	input cfg_s cfg,
	input wire logic serial_latch_pin,
	input wire logic [2:0] parallel_control_pins,
	// Filter coefficients h0..h11, shared by both channels.
	input wire logic [HALF_TAPS*COEF_W-1:0] coefs,
	// Output buses with enables.
	output logic [10:0] first_channel_bus,
	output logic first_channel_oe,
	output logic [10:0] second_channel_bus,
	output logic second_channel_oe,
	output logic out_valid,
	output logic out_is_a,
	// Status back in the system domain.
	output logic mux_active
);

	// Reset synchronised into the sample clock domain; declared early
	// because the datapath processes below already read it.
	logic srst_m, srst_l;

	// Two-flop crossing of the quasi-static configuration.
	cfg_s cfg_m, cfg_l;
	logic [3:0] pin_m, pin_l;
	always_ff @(posedge sample_clk) begin
		cfg_m <= cfg;
		cfg_l <= cfg_m;
		pin_m <= {serial_latch_pin, parallel_control_pins};
		pin_l <= pin_m;
	end

	// Multiplex decode, CMOS only, via field or pins.
	logic mux_l;
	assign mux_l = cfg_l.cmos_if &&
		(cfg_l.pwr_state == PWR_MUX || pin_l[2:0] == PWR_MUX);
	// Format: parallel mode follows the latch pin.
	logic fmt_tc;
	assign fmt_tc = cfg_l.parallel_cfg ? pin_l[3] : cfg_l.twos_comp;

	// Offset binary to two's complement conversion with clamp.
	function automatic logic [10:0] fmt(input logic [10:0] ob, input logic tc,
		input logic pos, input logic neg);
		logic [10:0] r;
		r = tc ? (ob ^ 11'h400) : ob;
		if (pos) begin
			r = tc ? TC_POS_FS : OB_POS_FS;
		end else if (neg) begin
			r = tc ? TC_NEG_FS : OB_NEG_FS;
		end
		return r;
	endfunction

	// Offset binary to signed and back, with saturation.
	function automatic logic signed [12:0] to_s(input logic [10:0] ob);
		return 13'($signed({2'b00, ob}) - $signed({2'b00, OB_MID}));
	endfunction
	function automatic logic [10:0] sat(input logic signed [24:0] v);
		logic [10:0] r;
		if (v > 25'sd1023) begin
			r = OB_POS_FS;
		end else if (v < -25'sd1024) begin
			r = OB_NEG_FS;
		end else begin
			r = 11'(v[10:0] ^ 11'h400);
		end
		return r;
	endfunction
	// Fine gain multiplier in Q10: 10^(code*0.05/20).
	function automatic logic [11:0] gain_q(input logic [3:0] c);
		logic [11:0] g;
		case (c)
			4'h0: g = 12'h400;
			4'h1: g = 12'h406;
			4'h2: g = 12'h40C;
			4'h3: g = 12'h412;
			4'h4: g = 12'h418;
			4'h5: g = 12'h41E;
			4'h6: g = 12'h424;
			4'h7: g = 12'h42A;
			4'h8: g = 12'h430;
			4'h9: g = 12'h436;
			4'hA: g = 12'h43D;
			default: g = 12'h400; // Unused codes add no gain.
		endcase
		return g;
	endfunction
	// Time constant field to shift amount.
	function automatic logic [4:0] tc_shift(input logic [2:0] f);
		logic [4:0] s;
		case (f)
			3'h0: s = 5'd27;
			3'h1: s = 5'd26;
			3'h2: s = 5'd25;
			3'h3: s = 5'd24;
			3'h4: s = 5'd28;
			3'h5: s = 5'd29;
			default: s = 5'd27;
		endcase
		return s;
	endfunction

	// Processing path per channel; index 0 is A, 1 is B.
	logic [10:0] raw [2];
	logic [1:0] ovp, ovn;
	assign raw[0] = core_a.code;
	assign raw[1] = core_b.code;
	assign ovp = {core_b.ovr_pos, core_a.ovr_pos};
	assign ovn = {core_b.ovr_neg, core_a.ovr_neg};

	// Offset loop: first-order estimate, est += (x - est) >> shift.
	logic signed [ACC_W-1:0] est [2];
	logic signed [12:0] corr [2];
	logic [10:0] stage1 [2];
	logic offset_live;
	assign offset_live = cfg_l.offset_en && !cfg_l.low_latency;
	always_ff @(posedge sample_clk) begin
		for (int c = 0; c < 2; c++) begin
			if (srst_l || !offset_live) begin
				est[c] <= '0;
			end else if (!cfg_l.offset_freeze) begin
				est[c] <= est[c] + ((($signed({{(ACC_W-13){corr[c][12]}},
					corr[c]}) <<< 29) - est[c]) >>> tc_shift(
					cfg_l.dc_offset_time_const));
			end
		end
	end
	// Subtraction every cycle; estimate limited to about +-10 mV codes.
	always_comb begin
		for (int c = 0; c < 2; c++) begin
			logic signed [12:0] e;
			e = 13'(est[c] >>> 29);
			if (e > 13'sd16) e = 13'sd16;
			if (e < -13'sd16) e = -13'sd16;
			corr[c] = to_s(raw[c]);
			stage1[c] = sat(25'(corr[c] - (offset_live ? e : 13'sd0)));
		end
	end

	// Fine gain, same value to both channels, only upward.
	logic [10:0] stage2 [2];
	logic [1:0] ovp2, ovn2;
	always_ff @(posedge sample_clk) begin
		for (int c = 0; c < 2; c++) begin
			stage2[c] <= sat(25'(($signed({1'b0, gain_q(cfg_l.fine_gain)})
				* to_s(stage1[c])) >>> 10));
		end
		ovp2 <= ovp;
		ovn2 <= ovn;
	end

	// Filter history: 24 taps per channel.
	logic signed [12:0] hist [2][TAPS];
	logic [2:0] dec_cnt;
	logic [2:0] dec_last;
	logic filt_on;
	logic [10:0] filt_out [2];
	logic filt_v;
	assign filt_on = cfg_l.dec_en && !cfg_l.noise_shaping_mode;
	always_comb begin
		case (cfg_l.dec_rate)
			2'h1: dec_last = 3'd3;
			2'h2: dec_last = 3'd7;
			default: dec_last = 3'd1;
		endcase
	end
	always_ff @(posedge sample_clk) begin
		for (int c = 0; c < 2; c++) begin
			hist[c][0] <= to_s(stage2[c]);
			for (int t = 1; t < TAPS; t++) hist[c][t] <= hist[c][t-1];
		end
		dec_cnt <= (srst_l || dec_cnt >= dec_last) ? 3'd0 : dec_cnt + 3'd1;
	end
	// Symmetric FIR; coefficients come in on the coefs port, filter_type is not read.
	always_ff @(posedge sample_clk) begin
		for (int c = 0; c < 2; c++) begin
			logic signed [31:0] acc;
			acc = '0;
			for (int k = 0; k < HALF_TAPS; k++) begin
				acc = acc + 32'($signed(coefs[k*COEF_W +: COEF_W]) *
					(hist[c][k] + hist[c][TAPS-1-k]));
			end
			filt_out[c] <= sat(25'(acc >>> FIR_SHIFT));
		end
		filt_v <= (dec_cnt == 3'd0);
	end

	// Latency alignment: pad to 14 normal, 10 bypass. The normal path has
	// the gain flop and the output flop besides the pad; bypass only the
	// output flop.
	localparam int PAD_N = LAT_NORMAL - 2;
	localparam int PAD_L = LAT_LOW - 1;
	logic [12:0] dly [2][PAD_N];
	logic [PAD_N-1:0] vdly;
	logic [10:0] sel [2];
	logic [1:0] sp, sn;
	logic sv;
	always_comb begin
		for (int c = 0; c < 2; c++) begin
			if (cfg_l.low_latency) begin
				sel[c] = raw[c];
				sp[c] = ovp[c];
				sn[c] = ovn[c];
			end else begin
				sel[c] = filt_on ? filt_out[c] : stage2[c];
				sp[c] = ovp2[c];
				sn[c] = ovn2[c];
			end
		end
		sv = cfg_l.low_latency || !filt_on || filt_v;
	end
	always_ff @(posedge sample_clk) begin
		for (int c = 0; c < 2; c++) begin
			dly[c][0] <= {sel[c], sp[c], sn[c]};
			for (int i = 1; i < PAD_N; i++) dly[c][i] <= dly[c][i-1];
		end
		vdly <= {vdly[PAD_N-2:0], sv};
	end
	// Tap point depends on mode; bypass uses a shorter chain.
	logic [12:0] tapv [2];
	logic tapval;
	assign tapv[0] = cfg_l.low_latency ? dly[0][PAD_L-1] : dly[0][PAD_N-1];
	assign tapv[1] = cfg_l.low_latency ? dly[1][PAD_L-1] : dly[1][PAD_N-1];
	assign tapval = cfg_l.low_latency ? vdly[PAD_L-1] : vdly[PAD_N-1];

	// Output stage; multiplexed mode sends A then B on the second bus.
	logic phase;
	logic [10:0] held_b;
	always_ff @(posedge sample_clk) begin
		srst_m <= srst;
		srst_l <= srst_m;
	end
	always_ff @(posedge sample_clk) begin
		if (srst_l) begin
			first_channel_bus <= 11'h000;
			second_channel_bus <= 11'h000;
			first_channel_oe <= 1'b0;
			second_channel_oe <= 1'b0;
			out_valid <= 1'b0;
			out_is_a <= 1'b0;
			phase <= 1'b0;
			held_b <= 11'h000;
		end else begin
			out_valid <= tapval;
			second_channel_oe <= 1'b1;
			first_channel_oe <= !mux_l;
			// The B slot always wins over a new sample, so the pair is
			// never split; at full rate every other pair is dropped,
			// which is why the receiver should keep to half rate.
			if (mux_l && phase) begin
				second_channel_bus <= held_b;
				out_valid <= 1'b1;
				out_is_a <= 1'b0;
				phase <= 1'b0;
			end else if (mux_l && tapval) begin
				second_channel_bus <= fmt(tapv[0][12:2], fmt_tc, tapv[0][1],
					tapv[0][0]);
				held_b <= fmt(tapv[1][12:2], fmt_tc, tapv[1][1], tapv[1][0]);
				out_is_a <= 1'b1;
				phase <= 1'b1;
			end else if (tapval) begin
				first_channel_bus <= fmt(tapv[0][12:2], fmt_tc, tapv[0][1],
					tapv[0][0]);
				second_channel_bus <= fmt(tapv[1][12:2], fmt_tc, tapv[1][1],
					tapv[1][0]);
				out_is_a <= 1'b0;
			end
		end
	end

	// Multiplex status back to the system clock, two flops.
	logic mux_m;
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			mux_m <= 1'b0;
			mux_active <= 1'b0;
		end else begin
			mux_m <= mux_l;
			mux_active <= mux_m;
		end
	end

	// Clamp codes follow the selected format.
	pos_clamp_a: assert property (@(posedge sample_clk) disable iff (srst_l)
		(tapval && !mux_l && tapv[1][1] && fmt_tc) |=>
		second_channel_bus == TC_POS_FS)
		else $error("positive clamp code wrong");
	neg_clamp_a: assert property (@(posedge sample_clk) disable iff (srst_l)
		(tapval && !mux_l && tapv[1][0] && !tapv[1][1] && !fmt_tc) |=>
		second_channel_bus == OB_NEG_FS)
		else $error("negative clamp code wrong");
	// First bus released one cycle after multiplexing starts.
	mux_release_a: assert property (@(posedge sample_clk) disable iff (srst_l)
		mux_l |=> !first_channel_oe)
		else $error("first bus driven in mux mode");
	mux_cmos_a: assert property (@(posedge sample_clk) disable iff (srst_l)
		!cfg_l.cmos_if |=> first_channel_oe)
		else $error("mux without cmos interface");
	sequence a_slot;
		out_is_a && out_valid;
	endsequence
	mux_order_a: assert property (@(posedge sample_clk) disable iff (srst_l)
		(mux_l && $stable(mux_l)) throughout a_slot |=> !out_is_a)
		else $error("channel B slot missing");
	freeze_hold_a: assert property (@(posedge sample_clk) disable iff (srst_l)
		(cfg_l.offset_freeze && $past(cfg_l.offset_freeze) && offset_live
		&& $past(offset_live)) |-> $stable(est[0]))
		else $error("estimate moved while frozen");
	offset_off_a: assert property (@(posedge sample_clk) disable iff (srst_l)
		!offset_live |=> est[1] == '0)
		else $error("estimate not cleared");
	filt_bypass_a: assert property (@(posedge sample_clk) disable iff (srst_l)
		(cfg_l.noise_shaping_mode || !cfg_l.dec_en) |-> sv)
		else $error("filter active when disabled");
endmodule

/* src/adc_proc_pkg.sv */
// Constants and carrier types for the converter output processing stage.
// Behaviour
// - Output code two's complement or offset binary.
// - Parallel configuration mode takes format from latch pin.
// - Positive overdrive clamps to positive full scale.
// - Negative overdrive clamps to negative full scale.
// - Multiplexing only with single-ended parallel interface.
// - Multiplexed samples interleave on second channel bus.
// - First channel bus released while multiplexed.
// - Multiplexing entered by power field or pins.
// - Default latency is 14 sample clocks.
// - Low latency is 10, processing bypassed.
// - Noise shaping mode bypasses the filter.
// - Offset loop estimates and subtracts every cycle.
// - Time constant field selects loop shift.
// - Freeze holds estimate, subtraction continues.
// - Offset correction disabled after reset.
// - Fine gain adds 0.05 dB steps, max ten.
// - Positive gain only, shared by both channels.
// - Decimation by 2, 4 or 8 with filter type; filter_type is never read, taps come from coefs.
// - Decimation filter disabled unless enabled.
// - Filter is 24 symmetric taps, scaled 2^-11.
// - Power state code 111 selects multiplexing.
package adc_proc_pkg;
	// Sample width and code points.
	localparam int SAMPLE_W = 11;
	localparam logic [10:0] OB_POS_FS = 11'h7FF;
	localparam logic [10:0] OB_NEG_FS = 11'h000;
	localparam logic [10:0] TC_POS_FS = 11'h3FF;
	localparam logic [10:0] TC_NEG_FS = 11'h400;
	localparam logic [10:0] OB_MID = 11'h400;
	// Latency in sample clocks, counted over the whole stage.
	localparam int LAT_NORMAL = 14;
	localparam int LAT_LOW = 10;
	// Power state code that selects multiplexed output.
	localparam logic [2:0] PWR_MUX = 3'h7;
	// Fine gain: highest used code; the Q10 multiplier per code is in gain_q.
	localparam logic [3:0] GAIN_MAX_CODE = 4'hA;
	// Filter taps and output scaling shift.
	localparam int TAPS = 24;
	localparam int HALF_TAPS = 12;
	localparam int COEF_W = 12;
	localparam int FIR_SHIFT = 11;
	// Offset estimate accumulator width (covers 2^29 time constant).
	localparam int ACC_W = 44;

	// Configuration bits supplied on plain ports.
	typedef struct packed {
		logic twos_comp;
		logic parallel_cfg;
		logic cmos_if;
		logic [2:0] pwr_state;
		logic low_latency;
		logic noise_shaping_mode;
		logic offset_en;
		logic offset_freeze;
		logic [2:0] dc_offset_time_const;
		logic [3:0] fine_gain;
		logic dec_en;
		logic [1:0] dec_rate;
		logic [2:0] filter_type;
	} cfg_s;

	// One converter sample with its overdrive flags.
	typedef struct packed {
		logic [10:0] code;
		logic ovr_pos;
		logic ovr_neg;
	} sample_s;
endpackage

/* test/adc_output_digital_processing_tb.sv */
// Self-checking bench for the converter output processing stage.
`timescale 1ns/1ps
module adc_output_digital_processing_tb;
	import adc_proc_pkg::*;
	// Clocks, reset and stimulus.
	logic sys_clk = 1'b0;
	logic sample_clk = 1'b0;
	logic srst = 1'b1;
	sample_s core_a = '0;
	sample_s core_b = '0;
	cfg_s cfg = '0;
	logic serial_latch_pin = 1'b0;
	logic [2:0] parallel_control_pins = 3'h0;
	logic [HALF_TAPS*COEF_W-1:0] coefs = 144'h400;
	// Design outputs and receiver captures.
	logic [10:0] fa, sb, got_a, got_b;
	logic fo, so, ov, isa, mx;
	logic [15:0] n_got;
	int n_errors = 0;
	int n_checks = 0;

	// System clock at 250 MHz.
	always #2 sys_clk = ~sys_clk;
	// Sample clock at 30 ns, under the rate that suits multiplexing; the
	// half-nanosecond skew keeps its edges clear of the stimulus edge.
	initial begin
		#6.5;
		forever #15 sample_clk = ~sample_clk;
	end

	adc_out_proc dut(.sys_clk(sys_clk), .srst(srst),
		.sample_clk(sample_clk), .core_a(core_a), .core_b(core_b),
		.cfg(cfg), .serial_latch_pin(serial_latch_pin),
		.parallel_control_pins(parallel_control_pins), .coefs(coefs),
		.first_channel_bus(fa), .first_channel_oe(fo),
		.second_channel_bus(sb), .second_channel_oe(so),
		.out_valid(ov), .out_is_a(isa), .mux_active(mx));

	sample_receiver rx(.sample_clk(sample_clk), .srst(srst), .bus_a(fa),
		.oe_a(fo), .bus_b(sb), .valid(ov), .is_a(isa), .got_a(got_a),
		.got_b(got_b), .n_got(n_got));

	// Ends the run with the verdict.
	task automatic stop_test();
		if (n_errors == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Range compare; an unknown value never counts as inside the range.
	task automatic chk(input logic [15:0] got, input logic [15:0] lo,
		input logic [15:0] hi);
		n_checks++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			$display("ERROR %0t got %h exp %h..%h", $time, got, lo, hi);
			n_errors++;
		end
	endtask

	// Waits n sample clocks, then returns on a stimulus edge.
	task automatic wait_s(input int n);
		repeat (n) @(posedge sample_clk);
		@(negedge sys_clk);
	endtask

	// Drives one sample on both cores and lets the pipeline fill.
	task automatic put(input logic [10:0] c, input logic p, input logic n);
		core_a = '{c, p, n};
		core_b = '{c, p, n};
		wait_s(30);
	endtask

	// Both formats, plain codes and both overdrive clamps.
	task automatic t_format();
		for (int f = 0; f < 2; f++) begin
			cfg.twos_comp = f[0];
			put(11'h123, 1'b0, 1'b0);
			chk(got_a, 11'h123 ^ {f[0], 10'h000}, 11'h123 ^ {f[0], 10'h000});
			chk(got_b, 11'h123 ^ {f[0], 10'h000}, 11'h123 ^ {f[0], 10'h000});
			put(11'h123, 1'b1, 1'b0);
			chk(got_b, f ? 16'h3FF : 16'h7FF, f ? 16'h3FF : 16'h7FF);
			put(11'h123, 1'b0, 1'b1);
			chk(got_a, f ? 16'h400 : 16'h000, f ? 16'h400 : 16'h000);
		end
		cfg.twos_comp = 1'b0;
	endtask

	// In parallel configuration the latch pin picks the format.
	task automatic t_latch();
		cfg.parallel_cfg = 1'b1;
		serial_latch_pin = 1'b1;
		put(11'h123, 1'b0, 1'b0);
		chk(got_b, 16'h523, 16'h523);
		serial_latch_pin = 1'b0;
		wait_s(30);
		chk(got_b, 16'h123, 16'h123);
		cfg.parallel_cfg = 1'b0;
	endtask

	// Counts sample clocks from a code change to its arrival on the bus.
	task automatic t_latency(input logic low);
		int n;
		cfg.low_latency = low;
		put(11'h111, 1'b0, 1'b0);
		core_b.code = 11'h222;
		n = 0;
		while (sb !== 11'h222 && n < 40) begin
			@(posedge sample_clk);
			#1;
			n++;
		end
		chk(n[15:0], low ? 16'h9 : 16'hD, low ? 16'hB : 16'hF);
		@(negedge sys_clk);
		cfg.low_latency = 1'b0;
	endtask

	// Multiplexing by power field and by pins, refused without CMOS.
	task automatic t_mux();
		cfg.cmos_if = 1'b1;
		for (int s = 0; s < 2; s++) begin
			cfg.pwr_state = s ? 3'h0 : PWR_MUX;
			parallel_control_pins = s ? 3'h7 : 3'h0;
			cfg.parallel_cfg = s[0];
			core_a = '{11'h0AA, 1'b0, 1'b0};
			core_b = '{11'h155, 1'b0, 1'b0};
			wait_s(30);
			chk(fo, 16'h0, 16'h0);
			chk(mx, 16'h1, 16'h1);
			chk(got_a, 16'h0AA, 16'h0AA);
			chk(got_b, 16'h155, 16'h155);
		end
		parallel_control_pins = 3'h0;
		cfg.parallel_cfg = 1'b0;
		cfg.pwr_state = PWR_MUX;
		cfg.cmos_if = 1'b0;
		wait_s(30);
		chk({mx, fo}, 16'h1, 16'h1);
		cfg.pwr_state = 3'h0;
	endtask

	// Output sample counts over 64 sample clocks for each decimation.
	task automatic t_rate();
		logic [15:0] c0;
		logic [15:0] ex;
		cfg.dec_en = 1'b1;
		for (int r = 0; r < 6; r++) begin
			cfg.dec_rate = (r < 3) ? r[1:0] : 2'h0;
			cfg.low_latency = (r == 3);
			cfg.dec_en = (r != 4);
			cfg.noise_shaping_mode = (r == 5);
			wait_s(30);
			c0 = n_got;
			wait_s(64);
			ex = (r < 3) ? (16'h0020 >> r) : 16'h0040;
			chk(n_got - c0, ex, ex);
		end
		cfg.low_latency = 1'b0;
		cfg.noise_shaping_mode = 1'b0;
		cfg.dec_en = 1'b0;
	endtask

	// Shared positive fine gain; unused codes add nothing.
	task automatic t_gain();
		cfg.fine_gain = GAIN_MAX_CODE;
		put(11'h600, 1'b0, 1'b0);
		chk(got_a, 16'h61D, 16'h620);
		chk(got_b, 16'h61D, 16'h620);
		cfg.fine_gain = 4'hB;
		wait_s(30);
		chk(got_b, 16'h600, 16'h600);
		cfg.fine_gain = 4'h0;
	endtask

	// Main sequence.
	initial begin
		repeat (36) @(negedge sys_clk);
		srst = 1'b0;
		wait_s(20);
		t_format();
		t_latch();
		t_latency(1'b0);
		t_latency(1'b1);
		t_mux();
		t_gain();
		t_rate();
		stop_test();
	end

	// Watchdog well beyond the expected run length.
	initial begin
		#150000;
		n_errors++;
		stop_test();
	end
endmodule

/* test/sample_receiver.sv */
// Receiver model that captures samples from the converter output buses.
`timescale 1ns/1ps
module sample_receiver
	import adc_proc_pkg::*;
(
	// Capture clock and reset.
	input wire logic sample_clk,
	input wire logic srst,
	// Output buses of the converter.
	input wire logic [10:0] bus_a,
	input wire logic oe_a,
	input wire logic [10:0] bus_b,
	input wire logic valid,
	input wire logic is_a,
	// Last captured samples and a count of captured pairs.
	output logic [10:0] got_a,
	output logic [10:0] got_b,
	output logic [15:0] n_got
);
	// Set on the slot after an A sample, when B follows on the shared bus.
	logic b_next;

	// Capture on valid; a released first bus reads back as a moving pattern.
	always_ff @(posedge sample_clk) begin
		if (srst) begin
			got_a <= 11'h000;
			got_b <= 11'h000;
			n_got <= 16'h0000;
			b_next <= 1'b0;
		end else if (!oe_a && valid && is_a) begin
			got_a <= bus_b;
			b_next <= 1'b1;
		end else if (b_next) begin
			got_b <= bus_b;
			b_next <= 1'b0;
			n_got <= n_got + 16'h0001;
		end else if (valid) begin
			got_a <= oe_a ? bus_a : ~got_a;
			got_b <= bus_b;
			n_got <= n_got + 16'h0001;
		end
	end
endmodule
